// [dv/ser_host_model.sv]
`timescale 1ns/1ps
module ser_host_model (
  input  wire logic clk_sys,
  output logic      cs_n,
  output logic      dclk,
  output logic      din,
  input  wire logic dout
);
  localparam int PH = 6;  // clk_sys cycles in the low data clock phase; the high phase takes two more
  initial begin
    cs_n = 1'b1;
    dclk = 1'b1;
    din  = 1'b0;
  end
  // Command byte then n data bytes, MSB first; wr is left aligned
  task automatic frame(input logic [7:0] cmd, input int n, input logic [63:0] wr, output logic [63:0] rd);
    logic [71:0] sh;
    sh = {cmd, wr};
    rd = '0;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (PH) @(posedge clk_sys);
    for (int i = 0; i < 8 * (n + 1); i++) begin
      dclk <= 1'b0;
      din  <= sh[71 - i];
      repeat (PH) @(posedge clk_sys);
      if (i >= 8) rd = {rd[62:0], dout};
      dclk <= 1'b1;
      repeat (PH + 2) @(posedge clk_sys);
    end
    cs_n <= 1'b1;
    din  <= ~din;  // Released line must not keep its value
    repeat (PH) @(posedge clk_sys);
  endtask : frame
endmodule : ser_host_model

// [dv/signaling_and_common_config_regs_properties.sv]
`timescale 1ns/1ps
module signaling_and_common_config_regs_properties (
  input wire logic                         clk_sys,
  input wire logic                         rst,
  input wire logic                         cs_n,
  input wire logic                         dout_oe_n,
  input wire logic [7:0]                   prog_sig_pair_out,
  input wire logic [7:0]                   prog_sig_pair_oe_n,
  input wire logic [3:0]                   prog_sig_third_out,
  input wire logic [3:0]                   prog_sig_third_oe_n,
  input wire logic                         irq_channels_one_two,
  input wire logic [3:0]                   ch_tx_enable,
  input wire logic [3:0]                   ch_tx_on_b,
  input wire sig_regs_pkg::slot_type [3:0] ch_tx_slot,
  input wire logic [3:0]                   ch_tx_disable,
  input wire logic [2:0]                   slot_offset
);
  import sig_regs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_pair_out_masked: assert property ((prog_sig_pair_out & prog_sig_pair_oe_n) == 8'h00)
    else $error("pair pin driven while input");
  a_third_out_masked: assert property ((prog_sig_third_out & prog_sig_third_oe_n) == 4'h0)
    else $error("third pin driven while input");
  a_reset_pins_in: assert property ($past(rst) |-> prog_sig_pair_oe_n == 8'hFF && prog_sig_third_oe_n == 4'hF)
    else $error("pins not inputs after reset");
  a_slot_clash: assert property (ch_tx_enable[1:0] == 2'b11 && ch_tx_on_b[0] == ch_tx_on_b[1] &&
    ch_tx_slot[0] == ch_tx_slot[1] |=> ch_tx_disable[1:0] == 2'b11)
    else $error("clashing talkers not disabled");
  a_lone_talker: assert property (ch_tx_enable == 4'h1 |=> ch_tx_disable == 4'h0)
    else $error("lone talker disabled");
  a_irq_clear_read: assert property ($fell(irq_channels_one_two) |-> !$past(cs_n, 3))
    else $error("interrupt fell outside a frame");
  a_dout_idle: assert property (cs_n [*6] |-> dout_oe_n)
    else $error("dout driven outside a frame");
  a_offset_quiet: assert property (!$stable(slot_offset) |-> !$past(cs_n, 4))
    else $error("offset changed without a write");
  a_dir_quiet: assert property (!$stable(prog_sig_pair_oe_n) |-> !$past(cs_n, 4))
    else $error("direction changed without a write");
endmodule : signaling_and_common_config_regs_properties

// [dv/signaling_and_common_config_regs_tb_top.sv]
`timescale 1ns/1ps
module signaling_and_common_config_regs_tb_top;
  import sig_regs_pkg::*;
  logic           clk_sys, rst, mclk, cs_n, dclk, din, dout, dout_oe_n, irq12, irq34, aux, chop;
  logic           dbl, txf, rxr, half, shf;
  logic [2:0]     offs;
  logic [7:0]     pin_in, pin_out, pin_oe_n;
  logic [3:0]     th_in, th_out, th_oe_n, pwr, tx_en, tx_b, tx_dis;
  slot_type [3:0] slot;
  logic [63:0]    rd;
  int             n_errors = 0;
  int             compares = 0;
  int             cyc = 0;
  ser_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .dclk(dclk), .din(din), .dout(dout));
  signaling_and_common_config_regs uut (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .dclk(dclk), .din(din),
    .dout(dout), .dout_oe_n(dout_oe_n), .mclk(mclk), .prog_sig_pair_in(pin_in), .prog_sig_pair_out(pin_out),
    .prog_sig_pair_oe_n(pin_oe_n), .prog_sig_third_in(th_in), .prog_sig_third_out(th_out),
    .prog_sig_third_oe_n(th_oe_n), .irq_channels_one_two(irq12), .irq_channels_three_four(irq34),
    .aux_clock_out_one(aux), .chopper_clock_out(chop), .ch_powered_up(pwr), .ch_tx_enable(tx_en),
    .ch_tx_on_b(tx_b), .ch_tx_slot(slot), .ch_tx_disable(tx_dis), .pcm_double_clock(dbl),
    .tx_start_falling(txf), .rx_sample_rising(rxr), .last_bit_half_drive(half), .highway_shift_one(shf),
    .slot_offset(offs));
  // System clock and a 5 MHz master clock locked to it
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    mclk = 1'b0;
    forever #100 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_n(input int got, input int exp, input string what);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("ERROR %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_n
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic t_reset();
    chk(pin_oe_n, 8'hFF, "pair dir");
    chk({th_oe_n, th_out}, 8'hF0, "third pins");
    chk({irq12, irq34, aux, chop, dout_oe_n, 3'h0}, 8'h38, "idle outs");
    host.frame(8'h3E, 7, '0, rd);
    chk(rd[55:48], 8'h00, "framing");
    chk(rd[47:40], 8'h02, "common");
    chk(rd[31:24], 8'h60, "third read");
    chk(rd[15:8], 8'hA5, "pair read");
  endtask : t_reset
  task automatic t_pins();
    host.frame(8'h1A, 3, {8'h0F, 8'h3C, 8'h00, 40'h0}, rd);
    chk(pin_oe_n, 8'hF0, "pair dir");
    chk(pin_out, 8'h0C, "pair out");
    host.frame(8'h1B, 1, {8'h95, 56'h0}, rd);
    chk({th_oe_n, th_out}, 8'hA1, "third");
    host.frame(8'h39, 1, '0, rd);
    chk(rd[7:0], 8'hAC, "mixed read");
  endtask : t_pins
  task automatic t_framing();
    logic [7:0] v[3] = '{8'hA9, 8'h56, 8'hFF};
    // Half drive only in single clocking, shift only in double clocking
    logic [7:0] e[3] = '{8'hA9, 8'h56, 8'hEF};
    foreach (v[i]) begin
      host.frame(8'h1E, 1, {v[i], 56'h0}, rd);
      chk({dbl, txf, rxr, half, shf, offs}, e[i], "framing");
    end
  endtask : t_framing
  task automatic t_soft();
    host.frame(8'h98, 0, '0, rd);
    chk(pin_oe_n, 8'hFF, "soft dir");
    chk({th_oe_n, dbl, txf, rxr, half}, 8'hF0, "soft misc");
  endtask : t_soft
  task automatic t_crash();
    tx_en <= 4'h3;
    @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    chk({tx_dis, 4'h0}, 8'h30, "clash A");
    host.frame(8'h3D, 1, '0, rd);
    chk(rd[7:0], 8'h22, "flag A");
    tx_b <= 4'h3;
    host.frame(8'h3D, 1, '0, rd);
    chk(rd[7:0], 8'h12, "flag B");
    tx_en <= 4'h1;
    repeat (3) @(posedge clk_sys);
    chk({tx_dis, 4'h0}, 8'h00, "no clash");
  endtask : t_crash
  task automatic t_debounce();
    int k;
    pin_in <= 8'h25;
    repeat (100) @(posedge clk_sys);
    chk({irq12, irq34, 6'h0}, 8'h00, "no debounce irq");
    host.frame(8'h1C, 1, {8'h1F, 56'h0}, rd);
    chk({aux, 7'h0}, 8'h00, "aux low");
    pin_in <= 8'h24;
    repeat (6000) @(posedge clk_sys);
    chk({irq12, 7'h0}, 8'h00, "early irq");
    for (k = 0; k < 7000 && irq12 !== 1'b1; k++) @(posedge clk_sys);
    chk({irq12, irq34, 6'h0}, 8'h80, "pair irq");
    host.frame(8'h39, 1, '0, rd);
    chk(rd[7:0], 8'h24, "captured");
    chk({irq12, 7'h0}, 8'h00, "irq cleared");
  endtask : t_debounce
  task automatic t_clocks();
    int   k;
    logic c;
    host.frame(8'h1D, 1, {8'h4C, 56'h0}, rd);
    c = chop;
    @(posedge clk_sys);
    chk({chop, c, 6'h0}, {~c, c, 6'h0}, "fast chop");
    pwr <= 4'h0;
    repeat (2) @(posedge clk_sys);
    chk({chop, 7'h0}, 8'h80, "chop parked");
    host.frame(8'h1C, 1, {8'h01, 56'h0}, rd);
    // 2048 master clock edges per ms, four system cycles per edge
    for (k = 0; k < 9000 && aux !== 1'b1; k++) @(posedge clk_sys);
    for (k = 0; k < 9000 && aux === 1'b1; k++) @(posedge clk_sys);
    chk_n(k, 8192, "aux half period");
  endtask : t_clocks
  initial begin
    rst = 1'b1;
    pin_in = 8'hA5;
    th_in = 4'h6;
    pwr = 4'hF;
    tx_en = 4'h0;
    tx_b = 4'h0;
    slot = '{7'h05, 7'h05, 7'h05, 7'h05};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_pins();
    t_framing();
    t_soft();
    t_crash();
    t_debounce();
    t_clocks();
    conclude();
  end
endmodule : signaling_and_common_config_regs_tb_top
bind signaling_and_common_config_regs signaling_and_common_config_regs_properties chk_i (.clk_sys(clk_sys),
  .rst(rst), .cs_n(cs_n), .dout_oe_n(dout_oe_n), .prog_sig_pair_out(prog_sig_pair_out),
  .prog_sig_pair_oe_n(prog_sig_pair_oe_n), .prog_sig_third_out(prog_sig_third_out),
  .prog_sig_third_oe_n(prog_sig_third_oe_n), .irq_channels_one_two(irq_channels_one_two),
  .ch_tx_enable(ch_tx_enable), .ch_tx_on_b(ch_tx_on_b), .ch_tx_slot(ch_tx_slot),
  .ch_tx_disable(ch_tx_disable), .slot_offset(slot_offset));

// [logic/sig_regs_defines.svh]
`ifndef SIG_REGS_DEFINES_SVH
`define SIG_REGS_DEFINES_SVH

// Extended register indices selected by the length field
`define XR_FIXED_SIG      3'h0
`define XR_PAIR_DATA      3'h1
`define XR_PAIR_DIR       3'h2
`define XR_THIRD          3'h3
`define XR_DEB_AUX        3'h4
`define XR_COMMON         3'h5
`define XR_FRAMING        3'h6

// Command byte layout
`define CMD_SOFT_RST_BIT  7
`define CMD_ZERO_BIT      6
`define CMD_RW_BIT        5
`define CMD_MARK_HI       4
`define CMD_MARK_LO       3
`define CMD_MARK_VALUE    2'h3

// Reset value of every extended register
`define XR_RESET          8'h00

// Common register field positions
`define CC_MCLK_HI        7
`define CC_MCLK_LO        6
`define CC_CHOP_HI        3
`define CC_CHOP_LO        2

// Framing register field positions
`define FR_DOUBLE_BIT     7
`define FR_TX_FALL_BIT    6
`define FR_RX_RISE_BIT    5
`define FR_HALF_DRV_BIT   4
`define FR_SHIFT_BIT      3
`define FR_OFFSET_HI      2

// Master clock rates in kHz, equal to master clock edges per millisecond
`define MCLK_KHZ_0        14'd1536
`define MCLK_KHZ_1        14'd2048
`define MCLK_KHZ_2        14'd4096
`define MCLK_KHZ_3        14'd8192

// Debounce step in milliseconds; the aux clock step is 1 ms
`define STEP_MS           5'd2

// Chopper synthesis from the system clock, all in kHz
`define CLK_SYS_KHZ       16'd20000
`define CHOP_512_STEP     16'd1024
`define CHOP_256_STEP     16'd512

`endif

// [logic/sig_regs_pkg.sv]
package sig_regs_pkg;

  // Serial frame phase, one-hot
  typedef enum logic [2:0] {
    PH_CMD  = 3'b001,
    PH_DATA = 3'b010,
    PH_SKIP = 3'b100
  } phase_type;

  typedef logic [7:0] xr_byte_type;
  typedef logic [6:0] slot_type;

endpackage : sig_regs_pkg

// [logic/sig_timing.sv]
`timescale 1ns/1ps
`include "sig_regs_defines.svh"
module sig_timing (
  input  wire logic   clk_sys,
  input  wire logic   rst,
  sig_timing_if.timing tif
);
  import sig_regs_pkg::*;

  // Master clock edges per millisecond for the selected rate
  function automatic logic [13:0] ms_div(input logic [1:0] sel);
    unique case (sel)
      2'h0: ms_div = `MCLK_KHZ_0;
      2'h1: ms_div = `MCLK_KHZ_1;
      2'h2: ms_div = `MCLK_KHZ_2;
      2'h3: ms_div = `MCLK_KHZ_3;
    endcase
  endfunction : ms_div

  logic        mclk_d_q;
  logic [13:0] mclk_cnt_q;
  logic        ms_tick_q;
  logic [5:0]  last_q [2];
  logic [4:0]  deb_cnt_q [2];
  logic [4:0]  aux_cnt_q;
  logic        aux_q;
  logic [15:0] acc_q;
  logic        chop_q;
  logic [11:0] deb_val_q;
  logic [1:0]  irq_q;

  assign tif.deb_val  = deb_val_q;
  assign tif.irq      = irq_q;
  assign tif.aux_clk  = aux_q;
  assign tif.chop_clk = chop_q;

  // Millisecond timebase counted on master clock rising edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mclk_d_q   <= 1'b0;
      mclk_cnt_q <= 14'h0000;
      ms_tick_q  <= 1'b0;
    end else begin
      mclk_d_q  <= tif.mclk_s;
      ms_tick_q <= 1'b0;
      if (tif.mclk_s && !mclk_d_q) begin
        if (mclk_cnt_q >= ms_div(tif.mclk_sel) - 14'h0001) begin
          mclk_cnt_q <= 14'h0000;
          ms_tick_q  <= 1'b1;
        end else begin
          mclk_cnt_q <= mclk_cnt_q + 14'h0001;
        end
      end
    end
  end

  // Per channel pair debounce, capture and interrupt
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      deb_val_q <= 12'h000;
      irq_q     <= 2'h0;
      for (int p = 0; p < 2; p++) begin
        last_q[p]    <= 6'h00;
        deb_cnt_q[p] <= 5'h00;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        last_q[p] <= tif.raw[p*6 +: 6];
        if (tif.irq_clr[p]) irq_q[p] <= 1'b0;
        if (tif.deb_code == 4'h0) begin
          deb_val_q[p*6 +: 6] <= tif.raw[p*6 +: 6];
          deb_cnt_q[p]        <= 5'h00;
        end else if (tif.raw[p*6 +: 6] != last_q[p]) begin
          deb_cnt_q[p] <= 5'h00;
        end else if (tif.raw[p*6 +: 6] != deb_val_q[p*6 +: 6]) begin
          if (deb_cnt_q[p] >= {tif.deb_code, 1'b0}) begin
            deb_val_q[p*6 +: 6] <= tif.raw[p*6 +: 6];
            deb_cnt_q[p]        <= 5'h00;
            irq_q[p]            <= 1'b1;
          end else if (ms_tick_q) begin
            deb_cnt_q[p] <= deb_cnt_q[p] + 5'h01;
          end
        end else begin
          deb_cnt_q[p] <= 5'h00;
        end
      end
    end
  end

  // Aux clock one: half period of code milliseconds for codes 1 to 14; code 0 holds it high, code 15 holds it low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_cnt_q <= 5'h00;
      aux_q     <= 1'b1;
    end else if (tif.aux_code == 4'h0) begin
      aux_cnt_q <= 5'h00;
      aux_q     <= 1'b1;
    end else if (tif.aux_code == 4'hF) begin
      aux_cnt_q <= 5'h00;
      aux_q     <= 1'b0;
    end else if (ms_tick_q) begin
      if (aux_cnt_q + 5'h01 >= {1'b0, tif.aux_code}) begin
        aux_cnt_q <= 5'h00;
        aux_q     <= ~aux_q;
      end else begin
        aux_cnt_q <= aux_cnt_q + 5'h01;
      end
    end
  end

  // Chopper clock by phase accumulation on the system clock for codes 1 and 2; code 3 toggles every cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_q  <= 16'h0000;
      chop_q <= 1'b1;
    end else if (tif.chop_code == 2'h0 || !tif.any_up) begin
      acc_q  <= 16'h0000;
      chop_q <= 1'b1;
    end else if (tif.chop_code == 2'h3) begin
      chop_q <= ~chop_q;
    end else begin
      if (acc_q + (tif.chop_code == 2'h1 ? `CHOP_512_STEP : `CHOP_256_STEP) >= `CLK_SYS_KHZ) begin
        acc_q  <= acc_q + (tif.chop_code == 2'h1 ? `CHOP_512_STEP : `CHOP_256_STEP) - `CLK_SYS_KHZ;
        chop_q <= ~chop_q;
      end else begin
        acc_q <= acc_q + (tif.chop_code == 2'h1 ? `CHOP_512_STEP : `CHOP_256_STEP);
      end
    end
  end

endmodule : sig_timing

// [logic/sig_timing_if.sv]
`timescale 1ns/1ps
interface sig_timing_if;
  logic [1:0]  mclk_sel;
  logic [3:0]  deb_code;
  logic [3:0]  aux_code;
  logic [1:0]  chop_code;
  logic        any_up;
  logic        mclk_s;
  logic [11:0] raw;
  logic [1:0]  irq_clr;
  logic [11:0] deb_val;
  logic [1:0]  irq;
  logic        aux_clk;
  logic        chop_clk;

  modport regs (output mclk_sel, deb_code, aux_code, chop_code, any_up, mclk_s, raw, irq_clr,
                input  deb_val, irq, aux_clk, chop_clk);
  modport timing (input  mclk_sel, deb_code, aux_code, chop_code, any_up, mclk_s, raw, irq_clr,
                  output deb_val, irq, aux_clk, chop_clk);
endinterface : sig_timing_if

// [logic/signaling_and_common_config_regs.sv]
`timescale 1ns/1ps
`include "sig_regs_defines.svh"
module signaling_and_common_config_regs #(
  parameter logic [1:0] VERSION_CODE = 2'h2  // Arbitrary silicon version value
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         cs_n,
  input  wire logic                         dclk,
  input  wire logic                         din,
  output logic                              dout,
  output logic                              dout_oe_n,
  input  wire logic                         mclk,
  input  wire logic [7:0]                   prog_sig_pair_in,
  output logic      [7:0]                   prog_sig_pair_out,
  output logic      [7:0]                   prog_sig_pair_oe_n,
  input  wire logic [3:0]                   prog_sig_third_in,
  output logic      [3:0]                   prog_sig_third_out,
  output logic      [3:0]                   prog_sig_third_oe_n,
  output logic                              irq_channels_one_two,
  output logic                              irq_channels_three_four,
  output logic                              aux_clock_out_one,
  output logic                              chopper_clock_out,
  input  wire logic [3:0]                   ch_powered_up,
  input  wire logic [3:0]                   ch_tx_enable,
  input  wire logic [3:0]                   ch_tx_on_b,
  input  wire sig_regs_pkg::slot_type [3:0] ch_tx_slot,
  output logic      [3:0]                   ch_tx_disable,
  output logic                              pcm_double_clock,
  output logic                              tx_start_falling,
  output logic                              rx_sample_rising,
  output logic                              last_bit_half_drive,
  output logic                              highway_shift_one,
  output logic      [2:0]                   slot_offset
);
  import sig_regs_pkg::*;

  // True when channel ch and another enabled channel share a slot on the given highway
  function automatic logic slot_clash(input logic [3:0] en, input logic [3:0] on_b,
                                      input slot_type [3:0] slot, input logic hwy_b, input int ch);
    slot_clash = 1'b0;
    for (int o = 0; o < 4; o++) begin
      if (o != ch && en[o] && en[ch] && on_b[o] == hwy_b && on_b[ch] == hwy_b && slot[o] == slot[ch])
        slot_clash = 1'b1;
    end
  endfunction : slot_clash

  sig_timing_if tif ();

  phase_type   phase_q;
  logic [1:0]  cs_sync_q;
  logic [2:0]  dclk_sync_q;
  logic [1:0]  din_sync_q;
  logic [1:0]  mclk_sync_q;
  logic [7:0]  pair_s1_q;
  logic [7:0]  pair_s2_q;
  logic [3:0]  third_s1_q;
  logic [3:0]  third_s2_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  rx_sh_q;
  logic [7:0]  tx_sh_q;
  logic        rw_q;
  logic [2:0]  idx_q;
  logic        soft_rst_q;
  logic        dclk_rise;
  logic        dclk_fall;
  logic        cs_act;
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic [2:0]  next_idx;
  logic        do_write;
  logic        do_load;
  logic        reg_rst;
  xr_byte_type pair_data_q;
  xr_byte_type pair_dir_q;
  xr_byte_type third_q;
  xr_byte_type deb_aux_q;
  xr_byte_type common_q;
  xr_byte_type framing_q;
  logic        coll_a_q;
  logic        coll_b_q;
  logic [7:0]  pair_rd;
  logic [3:0]  third_rd;
  xr_byte_type rd_val;
  logic [1:0]  irq_clr;

  // Synchronisers for every pin input
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_sync_q   <= 2'h3;
      dclk_sync_q <= 3'h0;
      din_sync_q  <= 2'h0;
      mclk_sync_q <= 2'h0;
      pair_s1_q   <= 8'h00;
      pair_s2_q   <= 8'h00;
      third_s1_q  <= 4'h0;
      third_s2_q  <= 4'h0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], cs_n};
      dclk_sync_q <= {dclk_sync_q[1:0], dclk};
      din_sync_q  <= {din_sync_q[0], din};
      mclk_sync_q <= {mclk_sync_q[0], mclk};
      pair_s1_q   <= prog_sig_pair_in;
      pair_s2_q   <= pair_s1_q;
      third_s1_q  <= prog_sig_third_in;
      third_s2_q  <= third_s1_q;
    end
  end

  // Serial port edges and byte assembly
  assign cs_act    = !cs_sync_q[1];
  assign dclk_rise = dclk_sync_q[1] && !dclk_sync_q[2];
  assign dclk_fall = !dclk_sync_q[1] && dclk_sync_q[2];
  assign byte_done = cs_act && dclk_rise && bit_cnt_q == 3'h7;
  assign rx_byte   = {rx_sh_q[6:0], din_sync_q[1]};
  assign next_idx  = (phase_q == PH_CMD) ? rx_byte[2:0] : idx_q - 3'h1;
  assign do_write  = byte_done && phase_q == PH_DATA && !rw_q;
  assign reg_rst   = rst || soft_rst_q;

  // Read-load happens when the byte that precedes a register completes
  always_comb begin
    do_load = 1'b0;
    if (byte_done && phase_q == PH_CMD)
      do_load = rx_byte[`CMD_ZERO_BIT] == 1'b0 && rx_byte[`CMD_MARK_HI:`CMD_MARK_LO] == `CMD_MARK_VALUE
                && rx_byte[`CMD_RW_BIT];
    else if (byte_done && phase_q == PH_DATA)
      do_load = rw_q && idx_q != 3'h0;
  end

  // Frame phase, length and direction tracking
  always_ff @(posedge clk_sys) begin
    if (rst || !cs_act) begin
      phase_q    <= PH_CMD;
      bit_cnt_q  <= 3'h0;
      rx_sh_q    <= 8'h00;
      rw_q       <= 1'b0;
      idx_q      <= 3'h0;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= 1'b0;
      if (dclk_rise) begin
        rx_sh_q   <= rx_byte;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (byte_done) begin
        unique case (phase_q)
          PH_CMD: begin
            if (rx_byte[`CMD_ZERO_BIT] == 1'b0 && rx_byte[`CMD_MARK_HI:`CMD_MARK_LO] == `CMD_MARK_VALUE) begin
              rw_q       <= rx_byte[`CMD_RW_BIT];
              idx_q      <= rx_byte[2:0];
              soft_rst_q <= rx_byte[`CMD_SOFT_RST_BIT];
              phase_q    <= PH_DATA;
            end else begin
              phase_q <= PH_SKIP;
            end
          end
          PH_DATA: begin
            idx_q <= next_idx;
            if (idx_q == 3'h0) phase_q <= PH_SKIP;
          end
          PH_SKIP: phase_q <= PH_SKIP;
        endcase
      end
    end
  end

  // Read value: inputs show captured level, outputs their latch
  always_comb begin
    pair_rd  = (pair_dir_q & pair_data_q) | (~pair_dir_q & {tif.deb_val[11:8], tif.deb_val[5:2]});
    third_rd = (third_q[3:0] & third_q[7:4]) | (~third_q[3:0] & {tif.deb_val[7:6], tif.deb_val[1:0]});
    unique case (next_idx)
      `XR_PAIR_DATA: rd_val = pair_rd;
      `XR_PAIR_DIR:  rd_val = pair_dir_q;
      `XR_THIRD:     rd_val = {third_rd, third_q[3:0]};
      `XR_DEB_AUX:   rd_val = deb_aux_q;
      `XR_COMMON:    rd_val = {common_q[`CC_MCLK_HI:`CC_MCLK_LO], coll_a_q, coll_b_q,
                               common_q[`CC_CHOP_HI:`CC_CHOP_LO], VERSION_CODE};
      `XR_FRAMING:   rd_val = framing_q;
      default:       rd_val = 8'h00;
    endcase
  end

  // Reading pair data or third-pin data clears both pair interrupts
  assign irq_clr = (do_load && (next_idx == `XR_PAIR_DATA || next_idx == `XR_THIRD)) ? 2'h3 : 2'h0;

  // Read data shifter, changes on falling serial clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_sh_q   <= 8'h00;
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
    end else begin
      dout_oe_n <= !(cs_act && (phase_q == PH_DATA || do_load) && (rw_q || do_load));
      if (do_load) begin
        tx_sh_q <= rd_val;
      end else if (cs_act && dclk_fall) begin
        dout    <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  // Pin data and direction registers
  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      pair_data_q <= `XR_RESET;
      pair_dir_q  <= `XR_RESET;
      third_q     <= `XR_RESET;
    end else if (do_write) begin
      if (idx_q == `XR_PAIR_DATA) pair_data_q <= rx_byte;
      if (idx_q == `XR_PAIR_DIR) pair_dir_q <= rx_byte;
      if (idx_q == `XR_THIRD) third_q <= rx_byte;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      deb_aux_q <= `XR_RESET;
      common_q  <= `XR_RESET;
      framing_q <= `XR_RESET;
    end else if (do_write) begin
      if (idx_q == `XR_DEB_AUX) deb_aux_q <= rx_byte;
      if (idx_q == `XR_COMMON) common_q <= rx_byte & 8'hCC;
      if (idx_q == `XR_FRAMING) framing_q <= rx_byte;
    end
  end

  // Pin drivers: enable is low while the pin is an output
  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      prog_sig_pair_out   <= 8'h00;
      prog_sig_pair_oe_n  <= 8'hFF;
      prog_sig_third_out  <= 4'h0;
      prog_sig_third_oe_n <= 4'hF;
    end else begin
      prog_sig_pair_out   <= pair_data_q & pair_dir_q;
      prog_sig_pair_oe_n  <= ~pair_dir_q;
      prog_sig_third_out  <= third_q[7:4] & third_q[3:0];
      prog_sig_third_oe_n <= ~third_q[3:0];
    end
  end

  // Collision detection per highway
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      coll_a_q      <= 1'b0;
      coll_b_q      <= 1'b0;
      ch_tx_disable <= 4'h0;
    end else begin
      coll_a_q <= 1'b0;
      coll_b_q <= 1'b0;
      for (int c = 0; c < 4; c++) begin
        ch_tx_disable[c] <= slot_clash(ch_tx_enable, ch_tx_on_b, ch_tx_slot, 1'b0, c)
                          | slot_clash(ch_tx_enable, ch_tx_on_b, ch_tx_slot, 1'b1, c);
        if (slot_clash(ch_tx_enable, ch_tx_on_b, ch_tx_slot, 1'b0, c)) coll_a_q <= 1'b1;
        if (slot_clash(ch_tx_enable, ch_tx_on_b, ch_tx_slot, 1'b1, c)) coll_b_q <= 1'b1;
      end
    end
  end

  // Highway framing controls
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcm_double_clock    <= 1'b0;
      tx_start_falling    <= 1'b0;
      rx_sample_rising    <= 1'b0;
      last_bit_half_drive <= 1'b0;
      highway_shift_one   <= 1'b0;
      slot_offset         <= 3'h0;
    end else begin
      pcm_double_clock    <= framing_q[`FR_DOUBLE_BIT];
      tx_start_falling    <= framing_q[`FR_TX_FALL_BIT];
      rx_sample_rising    <= framing_q[`FR_RX_RISE_BIT];
      last_bit_half_drive <= framing_q[`FR_HALF_DRV_BIT] && !framing_q[`FR_DOUBLE_BIT];
      highway_shift_one   <= framing_q[`FR_SHIFT_BIT] && framing_q[`FR_DOUBLE_BIT];
      slot_offset         <= framing_q[`FR_OFFSET_HI:0];
    end
  end

  // Timing block hookup
  assign tif.mclk_sel  = common_q[`CC_MCLK_HI:`CC_MCLK_LO];
  assign tif.deb_code  = deb_aux_q[7:4];
  assign tif.aux_code  = deb_aux_q[3:0];
  assign tif.chop_code = common_q[`CC_CHOP_HI:`CC_CHOP_LO];
  assign tif.any_up    = |ch_powered_up;
  assign tif.mclk_s    = mclk_sync_q[1];
  assign tif.raw       = {pair_s2_q[7:4] & ~pair_dir_q[7:4], third_s2_q[3:2] & ~third_q[3:2],
                          pair_s2_q[3:0] & ~pair_dir_q[3:0], third_s2_q[1:0] & ~third_q[1:0]};
  assign tif.irq_clr   = irq_clr;

  sig_timing u_timing (
    .clk_sys (clk_sys),
    .rst     (reg_rst),
    .tif     (tif)
  );

  // Outputs taken from timing flops
  assign irq_channels_one_two    = tif.irq[0];
  assign irq_channels_three_four = tif.irq[1];
  assign aux_clock_out_one       = tif.aux_clk;
  assign chopper_clock_out       = tif.chop_clk;

endmodule : signaling_and_common_config_regs
